// >>> drf_top.sv
/*
 * Device-side refresh, self-refresh and burst-select logic of a DDR3 DRAM.
 * Assumes the memory clock and all pins are slow enough to be oversampled
 * by REF_CLK_I, and that the controller keeps its own timing obligations.
 */
// What this block and its controller must do
// RQ1: A12 picks chopped four or eight beats.
// RQ2: Setup or hold faults corrupt only that write.
// RQ3: Strobe faults corrupt only that write location.
// RQ4: Refresh decoded from CS RAS CAS low.
// RQ5: Controller precharges all banks before refresh.
// RQ6: Internal counter addresses rows; banks end idle.
// RQ7: Only NOP or deselect during tRFC.
// RQ8: At most eight refreshes postponed.
// RQ9: At most eight refreshes pulled in.
// RQ10: Postponed refreshes done before self-refresh.
// RQ11: Self-refresh entry decoded with CKE low.
// RQ12: Banks idle and termination off before entry.
// RQ13: Stay in self-refresh at least tCKE.
// RQ14: DLL off on entry, reset on exit; the code does both only with MR1 A0 low.
// RQ15: Self-refresh ignores inputs, stops internal clock.
// RQ16: One internal refresh within tCKE of entry.
// RQ17: Clock stopped only after tCKSRE, restarted before exit.
// RQ18: Exit waits tXS and tXSDLL.
// RQ19: NOP during tXS, CKE high during tXSDLL.
// RQ20: ODT held low during tXSDLL.
// RQ21: Extra refresh before re-entering self-refresh.
// RQ22: ODT latency equals CWL plus AL minus two.
// RQ23: Controller tracks refresh debt within eight.
`include "drf_regs.svh"

module drf_top (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic CK_I,
  input wire logic CKE_I,
  input wire logic CS_N_I,
  input wire logic RAS_N_I,
  input wire logic CAS_N_I,
  input wire logic WE_N_I,
  input wire logic A12_I,
  input wire logic ODT_I,
  input wire logic WR_VIOL_I,
  input wire logic MR1_A0_I,
  input wire logic [3:0] CWL_I,
  input wire logic [3:0] AL_I,
  output logic BC4_O,
  output logic WR_BUSY_O,
  output logic WR_CORRUPT_O,
  output logic REFRESHING_O,
  output logic BANKS_IDLE_O,
  output logic [`DRF_ROW_W-1:0] ROW_ADDR_O,
  output logic SELF_REFRESH_O,
  output logic INT_REF_O,
  output logic INT_CLK_EN_O,
  output logic DLL_ON_O,
  output logic DLL_RST_O,
  output logic RTT_ON_O,
  output logic [4:0] ODT_LAT_O
);

  localparam logic [`DRF_CNT_W-1:0] RFC_CYC = `DRF_CNT_W'(`DRF_RFC_CYC);
  localparam logic [`DRF_CNT_W-1:0] XS_CYC = `DRF_CNT_W'(`DRF_XS_CYC);
  localparam logic [`DRF_CNT_W-1:0] CKE_CYC = `DRF_CNT_W'(`DRF_CKE_CYC);
  localparam logic [`DRF_CNT_W-1:0] REFI_CYC = `DRF_CNT_W'(`DRF_REFI_CYC);
  localparam logic [`DRF_CNT_W-1:0] CNT_ONE = `DRF_CNT_W'(1);
  localparam logic [`DRF_ROW_W-1:0] ROW_ONE = `DRF_ROW_W'(1);
  localparam logic [2:0] BEAT_ONE = 3'h1;

  drf_pkg::drf_pins_t pin_raw;
  drf_pkg::drf_pins_t p;
  drf_pkg::drf_regs_t r;
  drf_pkg::drf_regs_t next_r;
  logic ck_rise;
  logic sel;
  logic nop_des;
  logic is_ref;
  logic is_sre;
  logic is_rd;
  logic is_wr;

  // Every pin, the memory clock included, is oversampled through two flops.
  always_comb begin
    pin_raw.ck = CK_I;
    pin_raw.cke = CKE_I;
    pin_raw.cs_n = CS_N_I;
    pin_raw.ras_n = RAS_N_I;
    pin_raw.cas_n = CAS_N_I;
    pin_raw.we_n = WE_N_I;
    pin_raw.a12 = A12_I;
    pin_raw.odt = ODT_I;
    pin_raw.wr_viol = WR_VIOL_I;
    pin_raw.mr1_a0 = MR1_A0_I;
    pin_raw.cwl = CWL_I;
    pin_raw.al = AL_I;
  end

  drf_sync #(
    .W($bits(drf_pkg::drf_pins_t))
  ) drf_sync_inst (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .d_i(pin_raw),
    .q_o(p)
  );

  // Command decode happens on a rising edge of the sampled memory clock.
  assign ck_rise = p.ck && !r.ck_d;
  assign sel = !p.cs_n;
  assign nop_des = !sel || (p.ras_n && p.cas_n && p.we_n);
  assign is_ref = sel && !p.ras_n && !p.cas_n && p.we_n && p.cke;
  assign is_sre = sel && !p.ras_n && !p.cas_n && p.we_n && !p.cke;
  assign is_rd = sel && p.ras_n && !p.cas_n && p.we_n && p.cke;
  assign is_wr = sel && p.ras_n && !p.cas_n && !p.we_n && p.cke;

  // Next-state logic for the whole block.
  always_comb begin
    next_r = r;
    next_r.ck_d = p.ck;
    next_r.int_ref = 1'b0;
    next_r.dll_rst = 1'b0;
    next_r.corrupt = 1'b0;
    next_r.odt_lat = 5'(p.cwl + p.al) - `DRF_ODT_OFS; // see RQ22
    // Termination follows the pin except in self-refresh, where ODT is moot.
    next_r.rtt_on = p.odt && (r.state != drf_pkg::ST_SREF); // see RQ15
    if (r.cnt != '0) begin
      next_r.cnt = r.cnt - CNT_ONE;
    end
    // A strobe fault only flags the burst in flight; the controller never
    // leaves its path, so a bad write cannot hang the device.
    if (ck_rise && r.wr_left != '0) begin
      next_r.wr_left = r.wr_left - BEAT_ONE;
    end
    if (r.wr_left != '0 && p.wr_viol) begin
      next_r.corrupt = 1'b1; // see RQ2 RQ3
    end
    case (r.state)
      drf_pkg::ST_IDLE: begin
        if (ck_rise && is_ref) begin
          // Row comes from the internal counter, address pins unused.
          next_r.state = drf_pkg::ST_REF; // see RQ4
          next_r.refreshing = 1'b1;
          next_r.banks_idle = 1'b0;
          next_r.row = r.row + ROW_ONE; // see RQ6
          next_r.cnt = RFC_CYC;
        end else if (ck_rise && is_sre) begin
          next_r.state = drf_pkg::ST_SREF; // see RQ11
          next_r.sref = 1'b1;
          next_r.int_clk_en = 1'b0; // see RQ15
          next_r.dll_on = r.dll_on && p.mr1_a0; // see RQ14
          next_r.int_ref = 1'b1; // see RQ16
          next_r.row = r.row + ROW_ONE;
          next_r.cnt = CKE_CYC; // see RQ13
          next_r.ref_tmr = REFI_CYC;
        end else if (ck_rise && (is_rd || is_wr)) begin
          // A12 is a burst selector here, never a column bit.
          next_r.bc4 = !p.a12; // see RQ1
          if (is_wr) begin
            next_r.wr_left = p.a12 ? `DRF_BL8_CK : `DRF_BC4_CK;
          end
        end
      end
      drf_pkg::ST_REF: begin
        if (r.cnt == '0) begin
          next_r.state = drf_pkg::ST_IDLE;
          next_r.refreshing = 1'b0;
          next_r.banks_idle = 1'b1; // see RQ6
        end
      end
      drf_pkg::ST_SREF: begin
        // The built-in timer keeps refreshing with no memory clock.
        if (r.ref_tmr == '0) begin
          next_r.int_ref = 1'b1; // see RQ15
          next_r.row = r.row + ROW_ONE;
          next_r.ref_tmr = REFI_CYC;
        end else begin
          next_r.ref_tmr = r.ref_tmr - CNT_ONE;
        end
        // Only CKE high with NOP or deselect is looked at, and only after the least residency.
        if (ck_rise && p.cke && nop_des && r.cnt == '0) begin
          next_r.state = drf_pkg::ST_SRX; // see RQ13
          next_r.sref = 1'b0;
          next_r.int_clk_en = 1'b1;
          next_r.dll_on = 1'b1;
          next_r.dll_rst = !p.mr1_a0; // see RQ14
          next_r.cnt = XS_CYC;
        end
      end
      drf_pkg::ST_SRX: begin
        // Commands are ignored while a refresh in flight finishes.
        if (r.cnt == '0) begin
          next_r.state = drf_pkg::ST_IDLE;
        end
      end
      default: begin
        next_r.state = drf_pkg::ST_IDLE;
      end
    endcase
    next_r.wr_busy = (next_r.wr_left != '0); // see RQ2 RQ3
  end

  // Reset leaves the DLL on, the clock running and every bank idle.
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      r <= '0;
      r.state <= drf_pkg::ST_IDLE;
      r.banks_idle <= 1'b1;
      r.int_clk_en <= 1'b1;
      r.dll_on <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Outputs come straight from the state register.
  assign BC4_O = r.bc4;
  assign WR_BUSY_O = r.wr_busy;
  assign WR_CORRUPT_O = r.corrupt;
  assign REFRESHING_O = r.refreshing;
  assign BANKS_IDLE_O = r.banks_idle;
  assign ROW_ADDR_O = r.row;
  assign SELF_REFRESH_O = r.sref;
  assign INT_REF_O = r.int_ref;
  assign INT_CLK_EN_O = r.int_clk_en;
  assign DLL_ON_O = r.dll_on;
  assign DLL_RST_O = r.dll_rst;
  assign RTT_ON_O = r.rtt_on;
  assign ODT_LAT_O = r.odt_lat;

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);

  a_burst_select: assert property ( // see RQ1
    (r.state == drf_pkg::ST_IDLE && ck_rise && (is_rd || is_wr))
      |=> (BC4_O == !$past(p.a12)))
    else $error("Burst chop does not follow A12.");

  a_write_no_hang: assert property ( // see RQ2 RQ3
    (r.wr_left != '0 && p.wr_viol && r.state == drf_pkg::ST_IDLE)
      |=> WR_CORRUPT_O && r.state == drf_pkg::ST_IDLE)
    else $error("Write fault not contained to the write.");

  a_ref_decode: assert property ( // see RQ4
    (r.state == drf_pkg::ST_IDLE && ck_rise && is_ref)
      |=> REFRESHING_O && !BANKS_IDLE_O)
    else $error("Refresh command not taken.");

  a_ref_row_idle: assert property ( // see RQ6
    $rose(r.refreshing) |-> (r.row == $past(r.row) + ROW_ONE)
      ##1 (REFRESHING_O [*8]))
    else $error("Refresh row or duration wrong.");

  a_ref_ends_idle: assert property ( // see RQ6
    $fell(r.refreshing) |-> BANKS_IDLE_O && r.state == drf_pkg::ST_IDLE)
    else $error("Refresh did not leave banks idle.");

  a_sre_entry: assert property ( // see RQ11 RQ16
    (r.state == drf_pkg::ST_IDLE && ck_rise && is_sre)
      |=> SELF_REFRESH_O && INT_REF_O && !INT_CLK_EN_O)
    else $error("Self-refresh entry wrong.");

  a_sref_hold: assert property ( // see RQ13
    (SELF_REFRESH_O && !p.cke) |=> SELF_REFRESH_O)
    else $error("Self-refresh left with CKE low.");

  a_dll_cycle: assert property ( // see RQ14
    ($rose(r.sref) && !$past(p.mr1_a0)) |-> !DLL_ON_O)
    else $error("DLL not switched off on entry.");

  a_dll_reset: assert property ( // see RQ14
    ($fell(r.sref) && !$past(p.mr1_a0)) |-> (DLL_RST_O && DLL_ON_O))
    else $error("DLL not switched on and reset on exit.");

  a_sref_refresh_timer: assert property ( // see RQ15
    (SELF_REFRESH_O && r.ref_tmr == '0) |=> (INT_REF_O || !SELF_REFRESH_O))
    else $error("Self-refresh timer missed a refresh.");

  a_odt_latency: assert property ( // see RQ22
    !RST_I |=> (ODT_LAT_O == 5'($past(p.cwl) + $past(p.al)) - `DRF_ODT_OFS))
    else $error("ODT latency wrong.");

  c_refresh: cover property ($fell(r.refreshing));
  c_sref_exit: cover property ($fell(r.sref));
  c_bc4_write: cover property (ck_rise && is_wr && !p.a12);
  c_write_fault: cover property (WR_CORRUPT_O);

endmodule : drf_top

// >>> drf_regs.svh
/*
 * Timing and field constants for the refresh and self-refresh block.
 * Assumes a 125 MHz fabric clock; times are in nanoseconds.
 */
`ifndef DRF_REGS_SVH
`define DRF_REGS_SVH

`define DRF_CLK_NS 8
`define DRF_T_RFC_NS 160
`define DRF_T_XS_NS 170
`define DRF_T_CKE_NS 5
`define DRF_T_REFI_NS 7800

// Least times round up, the longest self-refresh interval rounds down.
`define DRF_RFC_CYC ((`DRF_T_RFC_NS + `DRF_CLK_NS - 1) / `DRF_CLK_NS)
`define DRF_XS_CYC ((`DRF_T_XS_NS + `DRF_CLK_NS - 1) / `DRF_CLK_NS)
`define DRF_CKE_CYC ((`DRF_T_CKE_NS + `DRF_CLK_NS - 1) / `DRF_CLK_NS)
`define DRF_REFI_CYC (`DRF_T_REFI_NS / `DRF_CLK_NS)

`define DRF_CNT_W 12
`define DRF_ROW_W 15
`define DRF_ODT_OFS 5'h02
`define DRF_BL8_CK 3'h4
`define DRF_BC4_CK 3'h2

`endif

// >>> drf_pkg.sv
/*
 * Types shared by the refresh and self-refresh block.
 * Assumes drf_regs.svh is on the include path.
 */
`include "drf_regs.svh"

package drf_pkg;

  // One-hot controller states.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_REF = 4'h2,
    ST_SREF = 4'h4,
    ST_SRX = 4'h8
  } drf_state_t;

  // Pin inputs as they travel through the synchroniser together.
  typedef struct packed {
    logic ck;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic a12;
    logic odt;
    logic wr_viol;
    logic mr1_a0;
    logic [3:0] cwl;
    logic [3:0] al;
  } drf_pins_t;

  // Whole state of the top module.
  typedef struct packed {
    drf_state_t state;
    logic ck_d;
    logic [`DRF_CNT_W-1:0] cnt;
    logic [`DRF_CNT_W-1:0] ref_tmr;
    logic [`DRF_ROW_W-1:0] row;
    logic [2:0] wr_left;
    logic wr_busy;
    logic bc4;
    logic refreshing;
    logic banks_idle;
    logic sref;
    logic int_clk_en;
    logic int_ref;
    logic dll_on;
    logic dll_rst;
    logic corrupt;
    logic rtt_on;
    logic [4:0] odt_lat;
  } drf_regs_t;

endpackage : drf_pkg

// >>> drf_sync.sv
/*
 * Two-flop synchroniser for a bundle of asynchronous levels.
 * Assumes every bit is a slow level; no bit is read between the flops.
 */
module drf_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } drf_sync_t;

  drf_sync_t r;
  drf_sync_t next_r;

  // The first stage feeds only the second stage.
  always_comb begin
    next_r.meta = d_i;
    next_r.stable = r.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q_o = r.stable;

endmodule : drf_sync

// >>> drf_ctl_model.sv
/*
 * Controller model: a free-running memory clock and the command pins.
 * Assumes clk_i is the 125 MHz fabric clock; one CK period is 20 cycles.
 */
`include "drf_regs.svh"
module drf_ctl_model (
  input wire logic clk_i,
  output logic ck_o,
  output logic cke_o,
  output logic [3:0] cmd_o,
  output logic a12_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  int debt;
  int tick;
  logic in_sr;
  logic ref_seen;

  // Idle bus at time zero: NOP with CKE high.
  initial begin
    ck_o = 1'b0;
    cnt = 4'h0;
    cke_o = 1'b1;
    cmd_o = 4'h7;
    a12_o = 1'b0;
    debt = 0;
    tick = 0;
    in_sr = 1'b0;
    ref_seen = 1'b1;
  end

  // Refresh bookkeeping: one refresh owed per interval outside
  // self-refresh, one paid per refresh, held within eight either way, and
  // a refresh required between an exit and the next entry.
  always @(posedge clk_i) begin
    tick <= (tick == `DRF_REFI_CYC) ? 0 : tick + 1;
    if (!ck_o && cnt == 4'h9 && cmd_o == 4'h1) begin
      in_sr <= !cke_o;
      ref_seen <= cke_o;
      if (cke_o && debt > -8) begin
        debt <= debt - 1;
      end
    end else begin
      if (!ck_o && cnt == 4'h9 && cke_o && in_sr) begin
        in_sr <= 1'b0;
        ref_seen <= 1'b0;
      end
      if (tick == `DRF_REFI_CYC && !in_sr && debt < 8) begin
        debt <= debt + 1;
      end
    end
  end

  // The clock runs free; halting it in self-refresh is allowed but unused.
  always @(posedge clk_i) begin
    cnt <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
    if (cnt == 4'h9) begin
      ck_o <= ~ck_o;
    end
  end

  // Returns at the edge where CK falls, half a period before the next rise.
  task automatic to_fall;
    @(posedge clk_i);
    while (!(ck_o && cnt == 4'h9)) begin
      @(posedge clk_i);
    end
  endtask : to_fall

  // One command held around one CK rise; NOP follows, so the refresh and
  // exit intervals see nothing else.
  task automatic cmd(input logic cke, input logic [3:0] c, input logic a);
    to_fall();
    cmd_o <= c;
    cke_o <= cke;
    a12_o <= a;
    to_fall();
    cmd_o <= 4'h7;
  endtask : cmd
endmodule : drf_ctl_model

// >>> tb_drf_top.sv
/*
 * Self-checking bench for drf_top driven by the controller model.
 * Assumes drf_regs.svh on the include path and the model compiled first.
 */
`include "drf_regs.svh"
module tb_drf_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, ck, cke, a12, odt, viol, a0;
  logic [3:0] cm, cwl, al;
  logic bc4, busy, cor, refr, idle, sr, iref, iclk, dll, drst, rtt;
  logic [`DRF_ROW_W-1:0] row;
  logic [4:0] olat;
  int fails = 0;
  int cmp_count = 0;
  int n_int = 0;
  int n_rst = 0;
  int n_cor = 0;
  int ref_run = 0;

  // Fabric clock, 8 ns.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  drf_ctl_model drf_ctl_model_inst (.clk_i(clk), .ck_o(ck), .cke_o(cke),
    .cmd_o(cm), .a12_o(a12));

  drf_top drf_top_inst (.REF_CLK_I(clk), .RST_I(rst), .CK_I(ck),
    .CKE_I(cke), .CS_N_I(cm[3]), .RAS_N_I(cm[2]), .CAS_N_I(cm[1]),
    .WE_N_I(cm[0]), .A12_I(a12), .ODT_I(odt), .WR_VIOL_I(viol),
    .MR1_A0_I(a0), .CWL_I(cwl), .AL_I(al), .BC4_O(bc4), .WR_BUSY_O(busy),
    .WR_CORRUPT_O(cor), .REFRESHING_O(refr), .BANKS_IDLE_O(idle),
    .ROW_ADDR_O(row), .SELF_REFRESH_O(sr), .INT_REF_O(iref),
    .INT_CLK_EN_O(iclk), .DLL_ON_O(dll), .DLL_RST_O(drst), .RTT_ON_O(rtt),
    .ODT_LAT_O(olat));

  // Internal-refresh and DLL-reset pulses last one cycle, so these flags are counted rather than caught.
  always @(posedge clk) begin
    if (iref === 1'b1) n_int++;
    if (drst === 1'b1) n_rst++;
    if (cor === 1'b1) n_cor++;
    if (refr === 1'b1) ref_run++;
  end

  task automatic stop_test;
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] g, input logic [15:0] e,
      input string m);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t %s: got %h want %h", $time, m, g, e);
    end
  endtask : chk

  function automatic logic pick(input int s);
    return (s == 0) ? refr : (s == 1) ? sr : busy;
  endfunction : pick

  // Bounded wait for a level; running out ends the run.
  task automatic wait_for(input int s, input logic v, input int b);
    for (int i = 0; i <= b; i++) begin
      @(posedge clk);
      #1;
      if (pick(s) === v) return;
    end
    fails++;
    $display("[ERR] %0t wait %0d timed out", $time, s);
    stop_test();
  endtask : wait_for

  // Cycles for which a level stays high, capped so it cannot hang.
  task automatic count_hi(input int s, output int n);
    n = 0;
    while (pick(s) === 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : count_hi

  task automatic t_reset;
    chk(idle, 1, "idle");
    chk({iclk, dll, sr, refr}, 4'hc, "flags");
    chk(olat, 4, "odt lat");
    @(posedge clk);
    cwl <= 4'h8;
    al <= 4'h7;
    odt <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk(olat, 13, "odt lat max");
    chk(rtt, 1, "rtt follows odt");
  endtask : t_reset

  // Refresh with A12 high, which the device must ignore.
  task automatic t_ref;
    logic [15:0] r;
    r = row;
    ref_run = 0;
    chk(idle, 1, "idle before");
    drf_ctl_model_inst.cmd(1, 4'h1, 1);
    wait_for(0, 1, 60);
    chk(idle, 0, "banks busy");
    chk(row, r + 1, "row step");
    wait_for(0, 0, 60);
    chk(ref_run, `DRF_RFC_CYC + 1, "refresh length");
    chk(idle, 1, "idle after");
  endtask : t_ref

  // Read or write; a fault marks the burst and nothing else.
  task automatic t_wr(input logic a, input logic rd, input logic v);
    int c, n;
    c = n_cor;
    @(posedge clk);
    viol <= v;
    drf_ctl_model_inst.cmd(1, rd ? 4'h5 : 4'h4, a);
    chk(bc4, !a, "chop");
    if (!rd) begin
      wait_for(2, 1, 60);
      count_hi(2, n);
      chk((n + 20) / 40, a ? 2 : 1, "burst ck");
      chk(n_cor > c, v, "corrupt");
    end
    @(posedge clk);
    viol <= 1'b0;
  endtask : t_wr

  task automatic t_sref(input logic v);
    logic [15:0] r;
    int i, d;
    @(posedge clk);
    a0 <= v;
    odt <= 1'b0;
    r = row;
    i = n_int;
    d = n_rst;
    chk(drf_ctl_model_inst.debt > 0, 0, "refresh owed");
    chk(drf_ctl_model_inst.ref_seen, 1, "no refresh");
    drf_ctl_model_inst.cmd(0, 4'h1, 0);
    wait_for(1, 1, 60);
    chk(iclk, 0, "int clk");
    chk(dll, v, "dll off");
    @(posedge clk);
    odt <= 1'b1;
    drf_ctl_model_inst.cmd(0, 4'h4, 0);
    chk({sr, rtt}, 2'h2, "ignored");
    chk(n_int - i, 1, "entry ref");
    chk(row, r + 1, "entry row");
    repeat (960) @(posedge clk);
    #1;
    chk(n_int - i, 2, "timer ref");
    chk(row, r + 2, "timer row");
    @(posedge clk);
    odt <= 1'b0;
    drf_ctl_model_inst.cmd(1, 4'h7, 0);
    wait_for(1, 0, 60);
    chk({iclk, dll}, 2'h3, "awake");
    chk(n_rst - d, !v, "dll reset");
    repeat (30) @(posedge clk);
  endtask : t_sref

  // Main sequence; every self-refresh is followed by a refresh.
  initial begin
    rst = 1'b1;
    viol = 1'b0;
    a0 = 1'b0;
    odt = 1'b0;
    cwl = 4'h6;
    al = 4'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    t_reset();
    t_ref();
    t_wr(0, 0, 1);
    t_wr(1, 1, 0);
    t_wr(1, 0, 0);
    t_ref();
    t_sref(0);
    t_ref();
    t_sref(1);
    t_ref();
    chk(drf_ctl_model_inst.debt < 8, 1, "debt bound");
    stop_test();
  end
endmodule : tb_drf_top
